// File: rtl/amms_edge.sv
// Edge detector for the command inputs of the motion sequencer
`timescale 1ns/1ps
`default_nettype none
module amms_edge (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire amms_pkg::amms_cmd_s i_cmd,
  output amms_pkg::amms_edge_s o_edge
);
  import amms_pkg::*;
  amms_cmd_s prev_reg; // Value of each input in the previous cycle

  // ********************************
  // Previous-cycle sample
  // ********************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prev_reg <= '0;
    end else if (i_ce) begin
      prev_reg <= i_cmd; // R19
    end
  end

  // Comparison with the held value, gated by the enable so a frozen cycle sees no edge
  assign o_edge.exe_rise = i_ce && i_cmd.execute_move && !prev_reg.execute_move; // R19
  assign o_edge.stop_rise = i_ce && i_cmd.stop && !prev_reg.stop; // R19
  assign o_edge.ack_rise = i_ce && i_cmd.ack && !prev_reg.ack; // R19
  assign o_edge.jog_fall = i_ce && ((prev_reg.jog_forward && !i_cmd.jog_forward) ||
                                    (prev_reg.jog_backward && !i_cmd.jog_backward)); // R5
endmodule
`default_nettype wire

// File: rtl/amms_pkg.sv
// Package of constants, types and register map for the axis motion mode sequencer
// Notes on behaviour
// R1 - Mode 1: absolute move to target on execute
// R2 - Mode 2: relative move by distance on execute
// R3 - Mode 3: jog forward/backward while inputs held
// R4 - Mode 4: ramped motor speed, position ignored
// R5 - Jog release: smooth stop with jog ramps
// R6 - Stop edge: ramp speed to zero, any mode
// R7 - After stop, locked until acknowledge edge
// R8 - Position monitor: plan or measured position
// R9 - Speed monitor: trajectory, zero mode 4/disabled
// R10 - Accel monitor shows trajectory acceleration
// R11 - Busy while moving toward target
// R12 - While busy ignore new setpoints and execute
// R13 - Busy false in modes 3, 4
// R14 - Main output carries motor speed setpoint
// R15 - Host supplies measured position, same unit
// R16 - Disabled: setpoint zero, no trajectory
// R17 - Done when setpoint exactly zero, modes 1-3
// R18 - Stop-lock flag clears on zero output and ack
// R19 - Edges found against previous cycle value
package amms_pkg;
  // ********************************
  // Data widths
  // ********************************
  localparam int AMMS_DW = 32;
  localparam int AMMS_AW = 8;
  localparam int AMMS_RAMP_SHIFT = 4; // Speed-to-position scaling shift
  // ********************************
  // Modes
  // ********************************
  localparam logic [2:0] AMMS_MODE_ABS = 3'h1;
  localparam logic [2:0] AMMS_MODE_REL = 3'h2;
  localparam logic [2:0] AMMS_MODE_JOG = 3'h3;
  localparam logic [2:0] AMMS_MODE_SPD = 3'h4;
  // ********************************
  // Register byte offsets
  // ********************************
  localparam logic [7:0] AMMS_REG_CTRL = 8'h00;   // enable, mode, command bits
  localparam logic [7:0] AMMS_REG_STATUS = 8'h04; // busy, done, lock (read)
  localparam logic [7:0] AMMS_REG_TARGET = 8'h08; // target position or distance
  localparam logic [7:0] AMMS_REG_TSPEED = 8'h0c; // target motor speed
  localparam logic [7:0] AMMS_REG_VMAX = 8'h10;   // max speed limit
  localparam logic [7:0] AMMS_REG_ACC = 8'h14;    // max accel limit
  localparam logic [7:0] AMMS_REG_STOPDEC = 8'h18;// stop deceleration
  localparam logic [7:0] AMMS_REG_IRQ_ST = 8'h1c; // sticky events, write one to clear
  localparam logic [7:0] AMMS_REG_IRQ_MASK = 8'h20;
  localparam logic [7:0] AMMS_REG_POS_MON = 8'h24;
  localparam logic [7:0] AMMS_REG_SPD_MON = 8'h28;
  localparam logic [7:0] AMMS_REG_ACC_MON = 8'h2c;
  // ********************************
  // Control bit positions
  // ********************************
  localparam int AMMS_CB_ENB = 0;
  localparam int AMMS_CB_MODE_LO = 1;
  localparam int AMMS_CB_EXE = 4;
  localparam int AMMS_CB_JFW = 5;
  localparam int AMMS_CB_JBW = 6;
  localparam int AMMS_CB_STOP = 7;
  localparam int AMMS_CB_ACK = 8;
  localparam int AMMS_NEV = 3; // events: move done, stop lock, ack
  localparam logic [1:0] AMMS_RESP_OKAY = 2'h0;
  localparam logic [1:0] AMMS_RESP_SLVERR = 2'h2;
  // Command inputs grouped
  typedef struct packed {
    logic execute_move;
    logic jog_forward;
    logic jog_backward;
    logic stop;
    logic ack;
  } amms_cmd_s;
  // Edge results of the command inputs
  typedef struct packed {
    logic exe_rise;
    logic jog_fall;
    logic stop_rise;
    logic ack_rise;
  } amms_edge_s;
  typedef enum logic [1:0] {
    AMMS_IDLE,
    AMMS_MOVE,
    AMMS_STOPPING,
    AMMS_LOCKED
  } amms_state_e;
endpackage

// File: rtl/amms_ramp.sv
// Rate-limited speed ramp: moves a signed speed toward a goal by a step per cycle
`timescale 1ns/1ps
`default_nettype none
module amms_ramp #(
  parameter int DW = 32
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_clear,
  input wire logic signed [DW-1:0] i_goal,
  input wire logic [DW-1:0] i_step,
  output logic signed [DW-1:0] o_speed,
  output logic signed [DW-1:0] o_accel
);
  logic signed [DW-1:0] speed_reg;
  logic signed [DW-1:0] accel_reg;
  logic signed [DW:0] diff;
  logic signed [DW:0] step_ext;
  logic signed [DW-1:0] speed_next;
  logic signed [DW-1:0] accel_next;

  // Difference is one bit wider so extreme goals cannot wrap
  assign diff = {i_goal[DW-1], i_goal} - {speed_reg[DW-1], speed_reg};
  assign step_ext = {1'b0, i_step};

  // ********************************
  // Next speed: clamp the change to one step
  // ********************************
  always_comb begin
    if (diff > step_ext) begin
      accel_next = $signed(i_step);
    end else if (diff < -step_ext) begin
      accel_next = -$signed(i_step);
    end else begin
      accel_next = diff[DW-1:0];
    end
    speed_next = speed_reg + accel_next;
  end

  // Zero step holds the speed: invalid parameters never start an axis at rest
  always_ff @(posedge i_clock) begin
    if (i_rst || (i_ce && i_clear)) begin
      speed_reg <= '0;
      accel_reg <= '0;
    end else if (i_ce) begin
      speed_reg <= speed_next;
      accel_reg <= accel_next;
    end
  end
  assign o_speed = speed_reg;
  assign o_accel = accel_reg;
endmodule
`default_nettype wire

// File: rtl/amms_top.sv
// Axis motion mode sequencer with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module amms_top (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic signed [amms_pkg::AMMS_DW-1:0] i_measured_position,
  input wire logic [amms_pkg::AMMS_AW-1:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [amms_pkg::AMMS_AW-1:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic signed [amms_pkg::AMMS_DW-1:0] o_speed_setpoint_out,
  output logic signed [amms_pkg::AMMS_DW-1:0] o_position_trajectory_mon,
  output logic signed [amms_pkg::AMMS_DW-1:0] o_speed_trajectory_mon,
  output logic signed [amms_pkg::AMMS_DW-1:0] o_accel_trajectory_mon,
  output logic o_busy,
  output logic o_done,
  output logic o_stop_lock_err,
  output logic o_irq
);
  import amms_pkg::*;

  // ********************************
  // Registers written by software
  // ********************************
  logic [31:0] ctrl_reg;         // Enable, mode and command levels
  logic signed [31:0] target_reg;// Target position or distance
  logic signed [31:0] tspeed_reg;// Target motor speed for mode 4
  logic [31:0] vmax_reg;         // Max speed limit of the active set
  logic [31:0] acc_reg;          // Max accel limit, step per cycle
  logic [31:0] stopdec_reg;      // Deceleration used by a stop
  logic [AMMS_NEV-1:0] irq_st_reg;
  logic [AMMS_NEV-1:0] irq_mask_reg;
  // ********************************
  // Core state
  // ********************************
  amms_state_e state_reg;
  logic signed [31:0] goal_pos_reg; // Latched move target
  logic signed [31:0] pos_plan_reg; // Planned position
  logic lock_reg;                   // Stop-lock error flag
  amms_cmd_s cmd;
  amms_edge_s edge_w;
  logic enb;
  logic [2:0] mode;
  logic in_pos_mode;
  logic signed [31:0] ramp_goal;
  logic [31:0] ramp_step;
  logic ramp_clear;
  logic signed [31:0] ramp_speed;
  logic signed [31:0] ramp_accel;
  logic signed [31:0] remaining;
  logic signed [31:0] speed_goal_pos;
  logic near_goal;
  localparam int BRAKE_W = 2 * AMMS_DW + AMMS_RAMP_SHIFT + 1; // Room for the braking products
  logic [31:0] rem_abs; // Distance still to go, magnitude
  logic [31:0] spd_abs; // Ramp speed, magnitude
  logic [BRAKE_W-1:0] brake_need; // Distance scaled by step and position shift
  logic [BRAKE_W-1:0] brake_have; // Speed products covered while braking to rest
  logic brake_reg; // Braking has begun; the move ends once at rest
  logic [AMMS_NEV-1:0] ev;

  assign enb = ctrl_reg[AMMS_CB_ENB];
  assign mode = ctrl_reg[AMMS_CB_MODE_LO +: 3];
  assign cmd.execute_move = ctrl_reg[AMMS_CB_EXE];
  assign cmd.jog_forward = ctrl_reg[AMMS_CB_JFW];
  assign cmd.jog_backward = ctrl_reg[AMMS_CB_JBW];
  assign cmd.stop = ctrl_reg[AMMS_CB_STOP];
  assign cmd.ack = ctrl_reg[AMMS_CB_ACK];
  assign in_pos_mode = (mode == AMMS_MODE_ABS) || (mode == AMMS_MODE_REL);

  amms_edge u_edge (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_cmd(cmd),
    .o_edge(edge_w)
  );

  // ********************************
  // Ramp goal and step selection
  // ********************************
  assign remaining = goal_pos_reg - pos_plan_reg;
  assign rem_abs = (remaining < 0) ? -remaining : remaining;
  assign spd_abs = (ramp_speed < 0) ? -ramp_speed : ramp_speed;
  // Stopping distance from speed v at step a is v*(v+a)/(a*2^(shift+1)); it is
  // cross-multiplied so no divider is needed
  assign brake_need = (BRAKE_W'(rem_abs) * BRAKE_W'(acc_reg)) << (AMMS_RAMP_SHIFT + 1);
  assign brake_have = BRAKE_W'(spd_abs) * (BRAKE_W'(spd_abs) + BRAKE_W'(acc_reg));
  assign near_goal = brake_need <= brake_have;
  // Once braking starts it runs to rest, so rounding cannot set up an oscillation
  assign speed_goal_pos = (near_goal || brake_reg) ? 32'sh0 :
    ((remaining > 0) ? $signed(vmax_reg) : -$signed(vmax_reg));
  always_comb begin
    ramp_goal = '0;
    ramp_step = acc_reg;
    if (state_reg == AMMS_STOPPING || state_reg == AMMS_LOCKED) begin
      ramp_step = stopdec_reg; // R6
    end else if (state_reg == AMMS_MOVE) begin
      ramp_goal = speed_goal_pos; // R1 R2
    end else if (mode == AMMS_MODE_JOG) begin
      if (cmd.jog_forward && !cmd.jog_backward) begin
        ramp_goal = $signed(vmax_reg); // R3
      end else if (cmd.jog_backward && !cmd.jog_forward) begin
        ramp_goal = -$signed(vmax_reg); // R3
      end else begin
        ramp_goal = '0; // R5
      end
    end else if (mode == AMMS_MODE_SPD) begin
      ramp_goal = tspeed_reg; // R4 R13
    end
  end
  assign ramp_clear = !enb; // R16

  amms_ramp #(.DW(AMMS_DW)) u_ramp (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_clear(ramp_clear),
    .i_goal(ramp_goal),
    .i_step(ramp_step),
    .o_speed(ramp_speed),
    .o_accel(ramp_accel)
  );

  // ********************************
  // Sequencer
  // ********************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      state_reg <= AMMS_IDLE;
      goal_pos_reg <= '0;
      brake_reg <= 1'b0;
      lock_reg <= 1'b0;
    end else if (i_ce) begin
      if (!enb) begin
        state_reg <= AMMS_IDLE; // R16
      end else if (edge_w.stop_rise) begin
        state_reg <= AMMS_STOPPING; // R6
        lock_reg <= 1'b1; // R18
      end else begin
        case (state_reg)
          AMMS_IDLE: begin
            // Execute edge only starts a move when not busy and not locked
            if (edge_w.exe_rise && in_pos_mode && !lock_reg) begin
              state_reg <= AMMS_MOVE;
              brake_reg <= 1'b0;
              goal_pos_reg <= (mode == AMMS_MODE_ABS) ? target_reg :
                (i_measured_position + target_reg); // R1 R2 R15
            end
          end
          AMMS_MOVE: begin
            // New execute edges and setpoints are ignored here
            if (near_goal) begin
              brake_reg <= 1'b1; // R1 R2
            end
            if ((near_goal || brake_reg) && ramp_speed == 32'sh0) begin
              state_reg <= AMMS_IDLE; // R11 R12
            end
          end
          AMMS_STOPPING: begin
            if (ramp_speed == 32'sh0) begin
              state_reg <= AMMS_LOCKED; // R7
            end
          end
          AMMS_LOCKED: begin
            if (edge_w.ack_rise && ramp_speed == 32'sh0) begin
              state_reg <= AMMS_IDLE; // R7
              lock_reg <= 1'b0; // R18
            end
          end
          default: state_reg <= AMMS_IDLE;
        endcase
      end
    end
  end

  // Planned position integrates the ramp speed; follows measurement otherwise
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pos_plan_reg <= '0;
    end else if (i_ce) begin
      if (state_reg == AMMS_MOVE || (enb && mode == AMMS_MODE_JOG &&
          state_reg == AMMS_IDLE)) begin
        pos_plan_reg <= pos_plan_reg + (ramp_speed >>> AMMS_RAMP_SHIFT);
      end else begin
        pos_plan_reg <= i_measured_position;
      end
    end
  end

  // ********************************
  // Monitor and control outputs
  // ********************************
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_speed_setpoint_out <= '0;
      o_position_trajectory_mon <= '0;
      o_speed_trajectory_mon <= '0;
      o_accel_trajectory_mon <= '0;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_stop_lock_err <= 1'b0;
    end else if (i_ce) begin
      o_speed_setpoint_out <= enb ? ramp_speed : '0; // R14 R16
      o_position_trajectory_mon <= (enb && in_pos_mode && state_reg == AMMS_MOVE) ?
        pos_plan_reg : i_measured_position; // R8
      o_speed_trajectory_mon <= (enb && mode != AMMS_MODE_SPD) ? ramp_speed : '0; // R9
      o_accel_trajectory_mon <= (enb && mode != AMMS_MODE_SPD) ? ramp_accel : '0; // R10
      o_busy <= enb && in_pos_mode && state_reg == AMMS_MOVE; // R11 R13
      o_done <= enb && (mode != AMMS_MODE_SPD) && (ramp_speed == 32'sh0); // R17
      o_stop_lock_err <= lock_reg; // R18
    end
  end

  // ********************************
  // Interrupt events
  // ********************************
  assign ev[0] = o_busy && !(state_reg == AMMS_MOVE);
  assign ev[1] = edge_w.stop_rise && enb;
  assign ev[2] = lock_reg && (state_reg == AMMS_LOCKED) && edge_w.ack_rise;

  // ********************************
  // AXI4-Lite slave
  // ********************************
  logic aw_held_reg;
  logic w_held_reg;
  logic [AMMS_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic do_write;
  logic wr_ok;
  logic [31:0] rd_word;
  logic rd_ok;
  logic [31:0] wmask;
  assign wmask = {{8{i_wstrb[3]}}, {8{i_wstrb[2]}}, {8{i_wstrb[1]}}, {8{i_wstrb[0]}}};
  assign do_write = aw_held_reg && w_held_reg && !o_bvalid;
  assign wr_ok = (awaddr_reg == AMMS_REG_CTRL) || (awaddr_reg == AMMS_REG_TARGET) ||
    (awaddr_reg == AMMS_REG_TSPEED) || (awaddr_reg == AMMS_REG_VMAX) ||
    (awaddr_reg == AMMS_REG_ACC) || (awaddr_reg == AMMS_REG_STOPDEC) ||
    (awaddr_reg == AMMS_REG_IRQ_ST) || (awaddr_reg == AMMS_REG_IRQ_MASK);
  always_comb begin
    rd_ok = 1'b1;
    rd_word = '0;
    if (i_araddr == AMMS_REG_CTRL) begin
      rd_word = ctrl_reg;
    end else if (i_araddr == AMMS_REG_STATUS) begin
      rd_word = {29'h0, o_stop_lock_err, o_done, o_busy};
    end else if (i_araddr == AMMS_REG_TARGET) begin
      rd_word = target_reg;
    end else if (i_araddr == AMMS_REG_TSPEED) begin
      rd_word = tspeed_reg;
    end else if (i_araddr == AMMS_REG_VMAX) begin
      rd_word = vmax_reg;
    end else if (i_araddr == AMMS_REG_ACC) begin
      rd_word = acc_reg;
    end else if (i_araddr == AMMS_REG_STOPDEC) begin
      rd_word = stopdec_reg;
    end else if (i_araddr == AMMS_REG_IRQ_ST) begin
      rd_word = {29'h0, irq_st_reg};
    end else if (i_araddr == AMMS_REG_IRQ_MASK) begin
      rd_word = {29'h0, irq_mask_reg};
    end else if (i_araddr == AMMS_REG_POS_MON) begin
      rd_word = o_position_trajectory_mon;
    end else if (i_araddr == AMMS_REG_SPD_MON) begin
      rd_word = o_speed_trajectory_mon;
    end else if (i_araddr == AMMS_REG_ACC_MON) begin
      rd_word = o_accel_trajectory_mon;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Address and data channels are taken independently, one write at a time
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      o_awready <= 1'b0;
      o_wready <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= AMMS_RESP_OKAY;
      o_arready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_rresp <= AMMS_RESP_OKAY;
    end else begin
      o_awready <= !aw_held_reg && !o_awready && !o_bvalid;
      o_wready <= !w_held_reg && !o_wready && !o_bvalid;
      if (o_awready && i_awvalid) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (o_wready && i_wvalid) begin
        w_held_reg <= 1'b1;
        wdata_reg <= i_wdata & wmask;
        o_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_ok ? AMMS_RESP_OKAY : AMMS_RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      o_arready <= !o_arready && !o_rvalid && i_arvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rdata <= rd_word;
        o_rresp <= rd_ok ? AMMS_RESP_OKAY : AMMS_RESP_SLVERR;
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // Register writes; sticky events win over a write-one clear
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ctrl_reg <= '0;
      target_reg <= '0;
      tspeed_reg <= '0;
      vmax_reg <= '0;
      acc_reg <= '0;
      stopdec_reg <= '0;
      irq_mask_reg <= '0;
      irq_st_reg <= '0;
      o_irq <= 1'b0;
    end else begin
      if (do_write && awaddr_reg == AMMS_REG_CTRL) begin
        ctrl_reg <= wdata_reg;
      end
      // Target, speed limit and accel limit changes are held off while a move is under way
      if (do_write && awaddr_reg == AMMS_REG_TARGET && !o_busy) begin
        target_reg <= wdata_reg; // R12
      end
      if (do_write && awaddr_reg == AMMS_REG_TSPEED) begin
        tspeed_reg <= wdata_reg;
      end
      if (do_write && awaddr_reg == AMMS_REG_VMAX && !o_busy) begin
        vmax_reg <= wdata_reg; // R12
      end
      if (do_write && awaddr_reg == AMMS_REG_ACC && !o_busy) begin
        acc_reg <= wdata_reg; // R12
      end
      if (do_write && awaddr_reg == AMMS_REG_STOPDEC) begin
        stopdec_reg <= wdata_reg;
      end
      if (do_write && awaddr_reg == AMMS_REG_IRQ_MASK) begin
        irq_mask_reg <= wdata_reg[AMMS_NEV-1:0];
      end
      irq_st_reg <= (irq_st_reg & ~((do_write && awaddr_reg == AMMS_REG_IRQ_ST) ?
        wdata_reg[AMMS_NEV-1:0] : '0)) | (i_ce ? ev : '0);
      o_irq <= |(irq_st_reg & irq_mask_reg);
    end
  end

  // ********************************
  // Checks
  // ********************************
  chk_disable_zero: assert property (@(posedge i_clock) disable iff (i_rst) // R16
    (i_ce && !enb) |=> (o_speed_setpoint_out == 0)) else $error("setpoint not zero");
  chk_busy_modes: assert property (@(posedge i_clock) disable iff (i_rst) // R13
    (i_ce && !in_pos_mode) |=> !o_busy) else $error("busy in jog or speed mode");
  chk_stop_locks: assert property (@(posedge i_clock) disable iff (i_rst) // R6
    (i_ce && enb && edge_w.stop_rise) |=> (state_reg == AMMS_STOPPING && lock_reg))
    else $error("stop not taken");
  chk_lock_holds: assert property (@(posedge i_clock) disable iff (i_rst) // R7
    (lock_reg && !edge_w.ack_rise && enb) |=> lock_reg) else $error("lock lost");
  chk_exe_ignored: assert property (@(posedge i_clock) disable iff (i_rst) // R12
    (state_reg == AMMS_MOVE && i_ce && enb && !edge_w.stop_rise) |=>
    $stable(goal_pos_reg)) else $error("target changed while moving");
  chk_done_zero: assert property (@(posedge i_clock) disable iff (i_rst) // R17
    (i_ce && enb && mode == AMMS_MODE_JOG) |=> (o_done == ($past(ramp_speed) == 0)))
    else $error("done mismatch");
  chk_speed_mon: assert property (@(posedge i_clock) disable iff (i_rst) // R9
    (i_ce && mode == AMMS_MODE_SPD) |=> (o_speed_trajectory_mon == 0))
    else $error("speed monitor not zero");
  chk_pos_mon: assert property (@(posedge i_clock) disable iff (i_rst) // R8
    (i_ce && !enb) |=> (o_position_trajectory_mon == $past(i_measured_position)))
    else $error("position monitor wrong");
endmodule
`default_nettype wire

// File: testbench/amms_drive_model.sv
// Behavioural frequency drive and axis that turn the speed setpoint into a position
`timescale 1ns/1ps
`default_nettype none
module amms_drive_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic signed [31:0] i_speed,
  output logic signed [31:0] o_position
);
  // Axis advances by the scaled speed each cycle; the sensor reports it in target units
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_position <= 32'sh0;
    end else begin
      o_position <= o_position + (i_speed >>> 4);
    end
  end
endmodule
`default_nettype wire

// File: testbench/amms_tb.sv
// Self-checking bench for the axis motion mode sequencer
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (a), (e)); end end
`define WT(c) begin k = 0; while (!(c) && k < 900) begin @(posedge i_clock); k++; end \
  if (k >= 900) fails++; end
module testbench;
  import amms_pkg::*;
  // Bus and control inputs, all given a value at time zero
  logic i_clock = 1'b0, i_rst = 1'b1, i_ce = 1'b1, i_awvalid = 1'b0, i_wvalid = 1'b0;
  logic i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, rv;
  logic [3:0] i_wstrb = 4'hf;
  logic [1:0] o_bresp, o_rresp, rs;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_busy, o_done, o_irq;
  logic o_stop_lock_err;
  logic signed [31:0] i_measured_position, o_speed_setpoint_out, o_position_trajectory_mon;
  logic signed [31:0] o_speed_trajectory_mon, o_accel_trajectory_mon, p0;
  int fails = 0, cmp_count = 0, k;
  always #50 i_clock = ~i_clock;
  amms_top i_dut (.*);
  amms_drive_model i_drive (.i_clock(i_clock), .i_rst(i_rst),
    .i_speed(o_speed_setpoint_out), .o_position(i_measured_position));
  // ****************************************
  // Bus tasks: every request held until its own ready edge
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clock);
    i_awaddr <= a;
    i_wdata <= d;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (o_awready) i_awvalid <= 1'b0;
      if (o_wready) i_wvalid <= 1'b0;
      r = o_bresp;
    end while (!(i_bready && o_bvalid) && n < 100);
    i_bready <= 1'b0;
    if (n >= 100) fails++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge i_clock);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
      if (o_arready) i_arvalid <= 1'b0;
      d = o_rdata;
      r = o_rresp;
    end while (!o_rvalid && n < 100);
    i_rready <= 1'b0;
    if (n >= 100) fails++;
  endtask
  // Reset state, unmapped and read-only places
  task t_regs();
    rd(AMMS_REG_STATUS, rv, rs);
    `CHK(rv, 32'h0)
    rd(8'h30, rv, rs);
    `CHK({rs, rv}, {AMMS_RESP_SLVERR, 32'h0})
    wr(AMMS_REG_STATUS, 32'h1, rs);
    `CHK(rs, AMMS_RESP_SLVERR)
  endtask
  // Absolute then relative move; the second execute and target are ignored while busy
  task t_move();
    wr(AMMS_REG_VMAX, 32'h40, rs);
    wr(AMMS_REG_ACC, 32'h10, rs);
    wr(AMMS_REG_IRQ_MASK, 32'h2, rs);
    wr(AMMS_REG_TARGET, 32'h100, rs);
    wr(AMMS_REG_CTRL, 32'h3, rs);
    wr(AMMS_REG_CTRL, 32'h13, rs);
    `WT(o_busy)
    `CHK(o_busy, 1'b1)
    wr(AMMS_REG_TARGET, 32'h800, rs);
    wr(AMMS_REG_CTRL, 32'h3, rs);
    wr(AMMS_REG_CTRL, 32'h13, rs);
    rd(AMMS_REG_TARGET, rv, rs);
    `CHK(rv, 32'h100)
    `WT(!o_busy)
    `CHK({o_done, o_speed_setpoint_out, o_irq}, {1'b1, 32'h0, 1'b0})
    rd(AMMS_REG_IRQ_ST, rv, rs);
    `CHK(rv[0], 1'b1)
    p0 = i_measured_position;
    wr(AMMS_REG_TARGET, 32'h80, rs);
    wr(AMMS_REG_CTRL, 32'h5, rs);
    wr(AMMS_REG_CTRL, 32'h15, rs);
    `WT(o_busy)
    `WT(!o_busy)
    `CHK(i_measured_position, p0 + 32'sh80)
  endtask
  // Jog both ways, smooth stop on release, never busy
  task t_jog();
    wr(AMMS_REG_CTRL, 32'h27, rs);
    `WT(o_speed_trajectory_mon > 0)
    `CHK({o_busy, o_accel_trajectory_mon}, {1'b0, 32'h10})
    wr(AMMS_REG_CTRL, 32'h7, rs);
    `WT(o_speed_setpoint_out == 0)
    `CHK(o_speed_trajectory_mon, 32'h0)
    wr(AMMS_REG_CTRL, 32'h47, rs);
    `WT(o_speed_setpoint_out < 0)
    `CHK(o_speed_trajectory_mon < 0, 1'b1)
    wr(AMMS_REG_CTRL, 32'h7, rs);
    `WT(o_speed_setpoint_out == 0)
  endtask
  // Speed mode ramp, then stop, lock, event and acknowledge
  task t_speed_stop();
    wr(AMMS_REG_TSPEED, 32'h20, rs);
    wr(AMMS_REG_CTRL, 32'h9, rs);
    `WT(o_speed_setpoint_out == 32'sh20)
    `CHK({o_speed_setpoint_out, o_speed_trajectory_mon, o_busy}, {32'h20, 32'h0, 1'b0})
    wr(AMMS_REG_STOPDEC, 32'h8, rs);
    wr(AMMS_REG_CTRL, 32'h89, rs);
    `WT(o_speed_setpoint_out == 0)
    `CHK({o_stop_lock_err, o_irq}, 2'b11)
    wr(AMMS_REG_CTRL, 32'h9, rs);
    repeat (20) @(posedge i_clock);
    `CHK({o_speed_setpoint_out, o_stop_lock_err}, {32'h0, 1'b1})
    `CHK(o_position_trajectory_mon, i_measured_position)
    wr(AMMS_REG_IRQ_ST, 32'h2, rs);
    `WT(!o_irq)
    wr(AMMS_REG_CTRL, 32'h109, rs);
    `WT(!o_stop_lock_err)
    `WT(o_speed_setpoint_out == 32'sh20)
    `CHK({o_stop_lock_err, o_speed_setpoint_out}, {1'b0, 32'h20})
  endtask
  // Disable forces the setpoint, speed and accel outputs to zero; the position monitor follows the measurement
  task t_off();
    wr(AMMS_REG_CTRL, 32'h0, rs);
    repeat (3) @(posedge i_clock);
    `CHK({o_speed_setpoint_out, o_speed_trajectory_mon, o_accel_trajectory_mon}, 96'h0)
    `CHK(o_position_trajectory_mon, i_measured_position)
  endtask
  task give_verdict();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Main sequence after an 8-cycle reset
  initial begin
    repeat (8) @(posedge i_clock);
    i_rst <= 1'b0;
    @(posedge i_clock);
    t_regs();
    t_move();
    t_jog();
    t_speed_stop();
    t_off();
    give_verdict();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #(100 * 30000);
    fails++;
    give_verdict();
  end
endmodule
`default_nettype wire
